// file: hdl/pixel_pan_composite_checksum.sv
// pixel path: sync/blank/overlay panning, pseudo/true compositing, frame signature
`default_nettype none
// Overview of operation
// - sync, blank and chosen overlay delayed 0 to 7 pixels by 3-bit field
// - field zero gives them exactly the pixel data latency; each step adds one
// - bit 3 chooses whether overlays pan with picture; low means pan
// - mode 00: select low gives true, high gives pseudo unless pseudo zero
// - mode 01: select ignored; zero pseudo gives true, else pseudo
// - mode 10: select high gives pseudo, low gives true
// - mode 11: always pseudo; mode from control bits 1 and 0
// - three 24-bit channel signatures set to all ones at vsync rise
// - pixels during blank leave the signatures untouched
// - signatures read back red, then green, then blue
// - two visible bytes form 16-bit word, first low, xored in
// - top bit clear: xor taps, shift, set bit 0; else shift only
module pixel_pan_composite_checksum (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pixel input from graphics controller
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [7:0] pseudo_in,
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic pixel_source_select,
  input wire logic sync_in,
  input wire logic blank_in,
  input wire logic vsync_in,
  input wire logic [1:0] overlay_in,
  // video output
  output logic out_valid,
  input wire logic out_ready,
  output logic out_pseudo_sel,
  output logic [7:0] out_pseudo,
  output logic [23:0] out_true,
  output logic out_sync,
  output logic out_blank,
  output logic [1:0] out_overlay,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);
  localparam int fw = pan_comp_pkg::fifo_width;

  // register state
  logic [3:0] pan_reg, pan_next;
  logic [1:0] comp_reg, comp_next;
  logic [1:0] rd_seq_reg, rd_seq_next;
  logic [31:0] rdata_reg, rdata_next;

  // signature state
  logic [23:0] sig_reg [3];
  logic [23:0] sig_next [3];
  logic [7:0] first_byte_reg [3];
  logic [7:0] first_byte_next [3];
  pan_comp_pkg::pair_state_t pair_reg, pair_next;
  logic vsync_d_reg, vsync_d_next;
  logic [31:0] frame_count_reg, frame_count_next;

  // pipeline: pixel data stage, then delay line for control
  logic [fw-1:0] fifo_din, fifo_dout;
  logic fifo_in_valid, fifo_in_ready;
  // ctl line holds {sync, blank} of the last eight accepted pixels
  logic [1:0] ctl_line_reg [pan_comp_pkg::pan_max_delay+1];
  logic [1:0] ctl_line_next [pan_comp_pkg::pan_max_delay+1];
  logic [1:0] ovl_line_reg [pan_comp_pkg::pan_max_delay+1];
  logic [1:0] ovl_line_next [pan_comp_pkg::pan_max_delay+1];
  logic [1:0] ctl_tap;
  logic [1:0] ovl_tap;
  logic step;
  logic vsync_rise;

  function automatic pan_comp_pkg::comp_mode_t mode_decode(input logic [1:0] m);
    case (m)
      2'h0: mode_decode = pan_comp_pkg::comp_pin_keyed;
      2'h1: mode_decode = pan_comp_pkg::comp_zero_keyed;
      2'h2: mode_decode = pan_comp_pkg::comp_pin_only;
      default: mode_decode = pan_comp_pkg::comp_pseudo_only;
    endcase
  endfunction : mode_decode

  function automatic logic pick_pseudo(input logic [1:0] m, input logic sel,
                                       input logic [7:0] p);
    case (mode_decode(m))
      pan_comp_pkg::comp_pin_keyed: pick_pseudo = sel && (p != 8'h00);
      pan_comp_pkg::comp_zero_keyed: pick_pseudo = (p != 8'h00);
      pan_comp_pkg::comp_pin_only: pick_pseudo = sel;
      pan_comp_pkg::comp_pseudo_only: pick_pseudo = 1'b1;
      default: pick_pseudo = 1'b1;
    endcase
  endfunction : pick_pseudo

  function automatic logic [23:0] lfsr_step(input logic [23:0] s, input logic [15:0] w);
    logic [23:0] x;
    x = s ^ {8'h00, w};
    // the top bit is tested after the word is folded in
    if (!x[pan_comp_pkg::signature_top_bit]) begin
      lfsr_step = {x[22:0] ^ pan_comp_pkg::signature_tap_mask[22:0], 1'b1};
    end else begin
      lfsr_step = {x[22:0], 1'b0};
    end
  endfunction : lfsr_step

  // the pipeline advances only when a pixel enters; a stalled output backs up the source
  assign step = pix_valid && fifo_in_ready;
  assign pix_ready = fifo_in_ready;
  // one edge detector serves both the signatures and the read order
  assign vsync_rise = vsync_in && !vsync_d_reg;

  // --- delay line for sync, blank, overlay ---
  // holding the line while nothing enters counts delay in pixels, not clocks
  always_comb begin
    ctl_line_next[0] = {sync_in, blank_in};
    ovl_line_next[0] = overlay_in;
    for (int i = 1; i <= pan_comp_pkg::pan_max_delay; i++) begin
      ctl_line_next[i] = ctl_line_reg[i-1];
      ovl_line_next[i] = ovl_line_reg[i-1];
    end
    if (!step) begin
      for (int i = 0; i <= pan_comp_pkg::pan_max_delay; i++) begin
        ctl_line_next[i] = ctl_line_reg[i];
        ovl_line_next[i] = ovl_line_reg[i];
      end
    end
  end

  generate
    for (genvar g = 0; g <= pan_comp_pkg::pan_max_delay; g++) begin : g_line
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ctl_line_reg[g] <= 2'h0;
          ovl_line_reg[g] <= 2'h0;
        end else begin
          ctl_line_reg[g] <= ctl_line_next[g];
          ovl_line_reg[g] <= ovl_line_next[g];
        end
      end
    end
  endgenerate

  // tap 0 is the current pixel, so zero delay matches pixel latency
  // a new delay takes effect on the next pixel; change it in flyback
  always_comb begin
    ctl_tap = ctl_line_next[pan_reg[2:0]];
    // low bit 3: overlay travels with pixel data
    if (!pan_reg[pan_comp_pkg::pan_overlay_bit]) begin
      ovl_tap = overlay_in;
    end else begin
      ovl_tap = ovl_line_next[pan_reg[2:0]];
    end
  end

  // fifo word: choice, sync, blank, overlay, pseudo byte, then true colour
  assign fifo_in_valid = pix_valid;
  assign fifo_din = {pick_pseudo(comp_reg, pixel_source_select, pseudo_in),
                     ctl_tap, ovl_tap,
                     pseudo_in, red_in, green_in, blue_in};

  // eight words of slack let the output side pause without losing pixels
  pixel_fifo #(
    .width(fw),
    .depth(pan_comp_pkg::fifo_depth)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_din),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_dout)
  );

  // output data taken straight from fifo storage (registered)
  // the pseudo byte rides along so the colour tables can still index it
  assign out_pseudo_sel = fifo_dout[36];
  assign out_sync = fifo_dout[35];
  assign out_blank = fifo_dout[34];
  assign out_overlay = fifo_dout[33:32];
  assign out_pseudo = fifo_dout[31:24];
  assign out_true = fifo_dout[23:0];

  // --- signatures ---
  // one byte per channel waits in first_byte_reg for its pair partner
  always_comb begin
    vsync_d_next = vsync_in;
    pair_next = pair_reg;
    frame_count_next = frame_count_reg;
    for (int c = 0; c < 3; c++) begin
      sig_next[c] = sig_reg[c];
      first_byte_next[c] = first_byte_reg[c];
    end
    if (vsync_rise) begin
      // pending half pair is dropped with the old frame
      // a pixel in the rise cycle counts in neither signature
      for (int c = 0; c < 3; c++) begin
        sig_next[c] = pan_comp_pkg::signature_init;
      end
      pair_next = pan_comp_pkg::pair_first;
      // frames seen, a software aid for spotting a missed vsync
      frame_count_next = frame_count_reg + 32'h0000_0001;
    end else if (step && !blank_in) begin
      case (pair_reg)
        pan_comp_pkg::pair_first, pan_comp_pkg::pair_idle: begin
          first_byte_next[0] = red_in;
          first_byte_next[1] = green_in;
          first_byte_next[2] = blue_in;
          pair_next = pan_comp_pkg::pair_second;
        end
        pan_comp_pkg::pair_second: begin
          sig_next[0] = lfsr_step(sig_reg[0], {red_in, first_byte_reg[0]});
          sig_next[1] = lfsr_step(sig_reg[1], {green_in, first_byte_reg[1]});
          sig_next[2] = lfsr_step(sig_reg[2], {blue_in, first_byte_reg[2]});
          pair_next = pan_comp_pkg::pair_first;
        end
        default: pair_next = pan_comp_pkg::pair_first;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 3; c++) begin
        sig_reg[c] <= pan_comp_pkg::signature_init;
        first_byte_reg[c] <= 8'h00;
      end
      pair_reg <= pan_comp_pkg::pair_idle;
      vsync_d_reg <= 1'b0;
      frame_count_reg <= 32'h0000_0000;
    end else begin
      for (int c = 0; c < 3; c++) begin
        sig_reg[c] <= sig_next[c];
        first_byte_reg[c] <= first_byte_next[c];
      end
      pair_reg <= pair_next;
      vsync_d_reg <= vsync_d_next;
      frame_count_reg <= frame_count_next;
    end
  end

  // --- register port ---
  always_comb begin
    pan_next = pan_reg;
    comp_next = comp_reg;
    rd_seq_next = rd_seq_reg;
    rdata_next = 32'h0000_0000;
    if (reg_write) begin
      case (reg_addr)
        pan_comp_pkg::pan_delay_control_addr: pan_next = reg_wdata[3:0];
        pan_comp_pkg::composite_select_control_addr: comp_next = reg_wdata[1:0];
        // a write to the signature register restarts the colour sequence unless a read comes in the same cycle
        pan_comp_pkg::frame_signature_addr: rd_seq_next = pan_comp_pkg::read_seq_red;
        // unmapped writes change nothing
        default: ;
      endcase
    end
    // a read in the rise cycle still wins and moves on from its old place
    if (vsync_rise) begin
      rd_seq_next = pan_comp_pkg::read_seq_red;
    end
    if (reg_read) begin
      case (reg_addr)
        pan_comp_pkg::pan_delay_control_addr: rdata_next = {28'h000_0000, pan_reg};
        pan_comp_pkg::composite_select_control_addr: rdata_next = {30'h0000_0000, comp_reg};
        pan_comp_pkg::frame_signature_addr: begin
          // red, green, blue then back to red
          // outside flyback the value read is still moving
          case (rd_seq_reg)
            2'h0: rdata_next = {8'h00, sig_reg[0]};
            2'h1: rdata_next = {8'h00, sig_reg[1]};
            default: rdata_next = {8'h00, sig_reg[2]};
          endcase
          rd_seq_next = (rd_seq_reg == 2'h2) ? pan_comp_pkg::read_seq_red
                                             : rd_seq_reg + 2'h1;
        end
        pan_comp_pkg::signature_status_addr: rdata_next = frame_count_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pan_reg <= pan_comp_pkg::pan_delay_control_reset;
      comp_reg <= pan_comp_pkg::composite_select_control_reset;
      rd_seq_reg <= pan_comp_pkg::read_seq_red;
      rdata_reg <= 32'h0000_0000;
    end else begin
      pan_reg <= pan_next;
      comp_reg <= comp_next;
      rd_seq_reg <= rd_seq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : pixel_pan_composite_checksum
`default_nettype wire

// file: shared/pan_comp_pkg.sv
// constants, register map and types for the pixel pan / composite / signature block
`default_nettype none
package pan_comp_pkg;
  // register indices on the plain register port
  localparam logic [2:0] pan_delay_control_addr = 3'h0;
  localparam logic [2:0] composite_select_control_addr = 3'h1;
  localparam logic [2:0] frame_signature_addr = 3'h2;
  localparam logic [2:0] signature_status_addr = 3'h3;
  // field positions
  localparam int pan_delay_lsb = 0;
  localparam int pan_delay_width = 3;
  localparam int pan_overlay_bit = 3;
  localparam int comp_mode_lsb = 0;
  localparam int comp_mode_width = 2;
  // reset values, signature tap mask and top bit
  localparam logic [3:0] pan_delay_control_reset = 4'h0;
  localparam logic [1:0] composite_select_control_reset = 2'h0;
  localparam logic [23:0] signature_init = 24'hff_ffff;
  localparam logic [23:0] signature_tap_mask = 24'h61_0000;
  localparam int signature_top_bit = 23;
  // pipeline depths and fifo
  localparam int pan_max_delay = 7;
  localparam int lut_latency = 2;
  localparam int fifo_depth = 8;
  localparam int fifo_width = 37;
  localparam logic [1:0] read_seq_red = 2'h0;

  typedef enum logic [3:0] {
    comp_pin_keyed = 4'b0001,
    comp_zero_keyed = 4'b0010,
    comp_pin_only = 4'b0100,
    comp_pseudo_only = 4'b1000
  } comp_mode_t;

  typedef enum logic [2:0] {
    pair_first = 3'b001,
    pair_second = 3'b010,
    pair_idle = 3'b100
  } pair_state_t;
endpackage : pan_comp_pkg
`default_nettype wire

// file: hdl/pixel_fifo.sv
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module pixel_fifo #(
  parameter int width = 27,
  parameter int depth = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  // pointers wrap by overflow, so depth must be a power of two
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [aw:0] count_reg, count_next;
  logic push, pop;

  assign in_ready = (count_reg != (aw+1)'(depth));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + aw'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + aw'(1) : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (aw+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (aw+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // storage has no reset; it is never read while empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule : pixel_fifo
`default_nettype wire

// file: verification/pixel_pan_composite_checksum_checker.sv
// port-level assertions for the pixel pan / composite / signature block
`default_nettype none
module pixel_pan_composite_checksum_checker (
  // clock and reset
  input wire logic clk, rst_b,
  // pixel input
  input wire logic pix_valid, pix_ready, pixel_source_select, sync_in, blank_in,
  input wire logic [7:0] pseudo_in,
  input wire logic [1:0] overlay_in,
  // video output
  input wire logic out_valid, out_ready, out_pseudo_sel, out_sync, out_blank,
  input wire logic [1:0] out_overlay,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic reg_write, reg_read
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] fill_reg, fill_next, pan_reg, pan_next;
  logic [1:0] mode_reg, mode_next;
  logic take, first, sel_exp;
  assign take = pix_valid && pix_ready;
  // a pixel entering an empty fifo is next at the head
  assign first = take && !out_valid;
  assign sel_exp = mode_reg[0] ? (mode_reg[1] || pseudo_in != 8'h00)
                               : (pixel_source_select && (mode_reg[1] || pseudo_in != 8'h00));
  always_comb begin
    fill_next = fill_reg + 4'(take) - 4'(out_valid && out_ready);
    pan_next = (reg_write && reg_addr == 3'h0) ? reg_wdata[3:0] : pan_reg;
    mode_next = (reg_write && reg_addr == 3'h1) ? reg_wdata[1:0] : mode_reg;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_reg <= 4'h0;
      pan_reg <= 4'h0;
      mode_reg <= 2'h0;
    end else begin
      fill_reg <= fill_next;
      pan_reg <= pan_next;
      mode_reg <= mode_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not cleared after its cycle");
  chk_unmapped_zero: assert property ($past(reg_read && reg_addr[2]) |-> reg_rdata == 0)
    else $error("unmapped read not zero");
  chk_ready_full: assert property (pix_ready == (fill_reg != 4'h8))
    else $error("input ready does not follow fifo fill");
  chk_valid_fill: assert property (out_valid == (fill_reg != 4'h0))
    else $error("output valid does not follow fifo fill");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable({out_pseudo_sel, out_sync, out_blank, out_overlay}))
    else $error("stalled output changed");
  chk_comp_select: assert property (first |=> out_pseudo_sel == $past(sel_exp))
    else $error("wrong pseudo or true choice");
  chk_pan_zero: assert property (first && pan_reg[2:0] == 3'h0
    |=> {out_sync, out_blank} == $past({sync_in, blank_in}))
    else $error("zero delay sync or blank misaligned");
  chk_overlay_pan: assert property (first && !pan_reg[3] |=> out_overlay == $past(overlay_in))
    else $error("panned overlay not with its pixel");
  cover property (!pix_ready);
  cover property (first && mode_reg == 2'h3);
  cover property (reg_read && reg_addr == 3'h2);
endmodule : pixel_pan_composite_checksum_checker
bind pixel_pan_composite_checksum pixel_pan_composite_checksum_checker chk_u (.clk, .rst_b,
  .pix_valid, .pix_ready, .pixel_source_select, .sync_in, .blank_in, .pseudo_in, .overlay_in,
  .out_valid, .out_ready, .out_pseudo_sel, .out_sync, .out_blank, .out_overlay, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_write, .reg_read);
`default_nettype wire

// file: verification/pixel_source_model.sv
// graphics controller model: frames of random pixels after a vsync pulse
`default_nettype none
module pixel_source_model (
  // clock and reset
  input wire logic clk, rst_b,
  // frame request
  input wire logic go, slow,
  input wire logic [7:0] count,
  output logic busy,
  // pixel stream
  output logic pix_valid, pixel_source_select, sync_in, blank_in, vsync_in,
  output logic [7:0] pseudo_in, red_in, green_in, blue_in,
  output logic [1:0] overlay_in,
  input wire logic pix_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left;
  assign busy = left != 8'h00 || pix_valid || vsync_in;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 8'h00;
      pix_valid <= 1'b0;
      vsync_in <= 1'b0;
      {pseudo_in, red_in, green_in, blue_in, pixel_source_select, sync_in, blank_in} <= '0;
      overlay_in <= 2'h0;
    end else if (go) begin
      left <= count;
      vsync_in <= 1'b1;
    end else if (!pix_valid || pix_ready) begin
      vsync_in <= 1'b0;
      if (left != 8'h00 && !vsync_in && !(slow && $urandom_range(1) == 0)) begin
        pix_valid <= 1'b1;
        left <= left - 8'h01;
      end else
        pix_valid <= 1'b0;
      // idle lines keep changing so nothing relies on a stale value
      {pseudo_in, red_in, green_in, blue_in} <= {($urandom_range(2) == 0 ? 8'h00 : 8'($urandom)),
                                                 24'($urandom)};
      {pixel_source_select, sync_in, blank_in, overlay_in} <= 5'($urandom);
    end
  end
endmodule : pixel_source_model
`default_nettype wire

// file: verification/pixel_pan_composite_checksum_bench.sv
// self-checking bench for the pixel pan / composite / signature block
`default_nettype none
module pixel_pan_composite_checksum_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic rst_b, busy, pix_valid, pix_ready, pixel_source_select, sync_in, blank_in, vsync_in;
  logic out_valid, out_pseudo_sel, out_sync, out_blank, vs_prev, half;
  logic clk = 1'b0, go = 1'b0, slow = 1'b0, hold_out = 1'b0, out_ready = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, e, m;
  logic [7:0] count = 8'h00, pseudo_in, red_in, green_in, blue_in, out_pseudo;
  logic [7:0] low_b [3], px [3];
  logic [1:0] overlay_in, out_overlay, mode = 2'h0;
  logic [23:0] out_true;
  logic [23:0] sig [3];
  logic [3:0] hist [8];
  logic [3:0] pan = 4'h0;
  logic [31:0] expq [$];
  logic [7:0] expp [$];
  int miscompares, check_count, taken, t0;
  always #50 clk = ~clk;
  pixel_pan_composite_checksum dut_u (.clk, .rst_b, .pix_valid, .pix_ready, .pseudo_in, .red_in,
    .green_in, .blue_in, .pixel_source_select, .sync_in, .blank_in, .vsync_in, .overlay_in,
    .out_valid, .out_ready, .out_pseudo_sel, .out_pseudo, .out_true, .out_sync, .out_blank,
    .out_overlay, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  pixel_source_model src_u (.clk, .rst_b, .go, .slow, .count, .busy, .pix_valid,
    .pixel_source_select, .sync_in, .blank_in, .vsync_in, .pseudo_in, .red_in, .green_in,
    .blue_in, .overlay_in, .pix_ready);
  function automatic logic [23:0] step(logic [23:0] c, logic [15:0] w);
    c = c ^ {8'h00, w};
    return c[23] ? {c[22:0], 1'b0} : {c[22:0] ^ pan_comp_pkg::signature_tap_mask[22:0], 1'b1};
  endfunction : step
  function automatic logic pick(logic [1:0] md, logic s, logic [7:0] p);
    return md[0] ? (md[1] || p != 8'h00) : (s && (md[1] || p != 8'h00));
  endfunction : pick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check("register read", reg_rdata, x);
  endtask : rd
  task automatic start(input logic [7:0] n);
    @(posedge clk);
    count <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : start
  task automatic settle();
    for (int i = 0; i < 3000 && (busy || out_valid); i++) @(posedge clk);
    check("stream drained", {31'h0, busy || out_valid}, 32'h0000_0000);
    repeat (4) @(posedge clk);
  endtask : settle
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // input monitor: expected pixel out and running signatures
  always @(posedge clk) begin
    if (!rst_b) begin
      vs_prev = 1'b0;
      half = 1'b0;
      sig = '{3{24'hff_ffff}};
    end else begin
      px = '{red_in, green_in, blue_in};
      if (pix_valid && pix_ready) begin
        for (int i = 7; i > 0; i--) hist[i] = hist[i - 1];
        hist[0] = {sync_in, blank_in, overlay_in};
        expq.push_back({taken < 7, 2'h0, pick(mode, pixel_source_select, pseudo_in), red_in,
          green_in, blue_in, hist[pan[2:0]][3:2], pan[3] ? hist[pan[2:0]][1:0] : overlay_in});
        expp.push_back(pseudo_in);
        taken++;
      end
      if (vsync_in && !vs_prev) begin
        sig = '{3{24'hff_ffff}};
        half = 1'b0;
      end else if (pix_valid && pix_ready && !blank_in) begin
        for (int c = 0; c < 3; c++)
          if (half) sig[c] = step(sig[c], {px[c], low_b[c]});
          else low_b[c] = px[c];
        half = !half;
      end
      vs_prev = vsync_in;
    end
  end
  always @(posedge clk) begin
    if (rst_b && out_valid && out_ready) begin
      e = expq.pop_front();
      // history before the eighth pixel after reset is unknown
      m = e[31] ? 32'h1fff_fff0 : 32'h1fff_ffff;
      check("pixel out", {3'h0, out_pseudo_sel, out_true, out_sync, out_blank, out_overlay} & m,
        e & m);
      check("pseudo out", {24'h0, out_pseudo}, {24'h0, expp.pop_front()});
    end
    out_ready <= !hold_out && $urandom_range(3) != 0;
  end
  initial begin
    #(100 * 50000);
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(44));
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(3'h0, 32'h0000_0000);
    rd(3'h1, 32'h0000_0000);
    rd(3'h2, 32'h00ff_ffff);
    rd(3'h7, 32'h0000_0000);
    $display("test reset values done");
    for (int t = 0; t < 6; t++) begin
      pan = t == 0 ? 4'h0 : (t == 1 ? 4'hf : 4'($urandom));
      mode = 2'(t);
      slow = t[0];
      wr(3'h0, {28'h0, pan});
      wr(3'h1, {30'h0, mode});
      wr(3'h5, 32'hffff_ffff);
      rd(3'h0, {28'h0, pan});
      rd(3'h1, {30'h0, mode});
      // an odd count of unblanked pixels leaves a half pair that the next vsync must drop
      start(8'(40 + t));
      settle();
      rd(3'h2, {8'h0, sig[0]});
      rd(3'h2, {8'h0, sig[1]});
      rd(3'h2, {8'h0, sig[2]});
      rd(3'h2, {8'h0, sig[0]});
      rd(3'h3, 32'(t + 1));
      wr(3'h2, 32'h0000_0000);
      rd(3'h2, {8'h0, sig[0]});
      $display("test frame %0d done", t);
    end
    slow = 1'b0;
    hold_out <= 1'b1;
    t0 = taken;
    start(8'h0c);
    repeat (30) @(posedge clk);
    check("ready when full", {31'h0, pix_ready}, 32'h0000_0000);
    check("pixels held", 32'(taken - t0), 32'h0000_0008);
    hold_out <= 1'b0;
    settle();
    rd(3'h2, {8'h0, sig[0]});
    $display("test fifo full done");
    final_report();
  end
endmodule : pixel_pan_composite_checksum_bench
`default_nettype wire
